// File: hdl/sds_core.sv
// speed display scaling and sixteen point linearization
`timescale 1ns/1ps
// Operation
// [RL1] The display value is refreshed once per programmed period of 0.05 to 1.00 s, 0.10 s by default; linearized, disp_value first shows the raw value.
// [RL2] Unit selector 0 shows Hz and 1 shows kHz, with the threshold value staying in Hz for both.
// [RL3] Unit selector 2 shows revolutions per second as frequency over pulses per revolution.
// [RL4] Unit selector 3 shows revolutions per minute as sixty times frequency over pulses per revolution.
// [RL5] Unit selector 4 shows frequency times multiplier over pulses per revolution.
// [RL6] Pulses per revolution range 1 to 99999, default 1, used only with selectors 2 to 4.
// [RL7] The multiplier ranges 1 to 200, default 1, used only with selector 4.
// [RL8] With selectors 2 to 4 the threshold value is in the display units instead of Hz.
// [RL9] Sixteen original and substitute point pairs are held in thousandths of a percent, -100000 to 100000.
// [RL10] Between two adjacent points the substitute follows straight-line interpolation.
// [RL11] The configuring party programs original points strictly increasing from point one to sixteen.
// [RL12] New settings apply from the next computed value and never disturb the frequency input.
module sds_core #(
  parameter int unsigned CYC_PER_CS = sds_pkg::CYC_PER_CS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] freq_hz,
  input wire sds_pkg::sds_cfg_s cfg,
  input wire sds_pkg::sds_pt_wr_s pt_wr,
  output logic [31:0] disp_value,
  output logic [31:0] sw_value,
  output logic disp_valid,
  output logic busy
);
  typedef struct packed {
    sds_pkg::sds_st_e st;
    logic [23:0] cnt_cs;
    logic [6:0] cnt_per;
    logic [31:0] freq_s;
    sds_pkg::sds_cfg_s cfg_s;
    logic [15:0][19:0] px;
    logic [15:0][19:0] py;
    logic [55:0] num;
    logic [31:0] den;
    logic [31:0] rem;
    logic [55:0] quo;
    logic [5:0] bitc;
    logic [3:0] seg;
    logic signed [19:0] pct;
    logic signed [19:0] y0;
    logic neg;
    logic [31:0] disp_value;
    logic [31:0] sw_value;
    logic disp_valid;
    logic busy;
  } sds_state_s;

  sds_state_s state_reg;
  sds_state_s state_next;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [6:0] per;
    logic [32:0] t;
    logic q1;
    logic [55:0] nq;
    logic [17:0] k;
    logic [16:0] ppr;
    logic [7:0] mult;
    logic signed [20:0] dx;
    logic signed [20:0] dy;
    logic signed [20:0] dp;
    logic signed [41:0] prod;
    logic signed [20:0] lin;
    per = cfg.upd_cs;
    t = '0;
    q1 = 1'b0;
    nq = '0;
    k = sds_pkg::K_MILLI;
    ppr = sds_pkg::PPR_MIN;
    mult = sds_pkg::MULT_MIN;
    dx = '0;
    dy = '0;
    dp = '0;
    prod = '0;
    lin = '0;
    state_next = state_reg;
    state_next.disp_valid = 1'b0;
    if (per == 7'h00) begin
      per = sds_pkg::UPD_DEF_CS; // see [RL1]
    end else if (per < sds_pkg::UPD_MIN_CS) begin
      per = sds_pkg::UPD_MIN_CS;
    end else if (per > sds_pkg::UPD_MAX_CS) begin
      per = sds_pkg::UPD_MAX_CS;
    end
    // period timer keeps counting while busy, so only a computation longer than the period stretches it
    if (state_reg.cnt_cs == 24'(CYC_PER_CS - 1)) begin
      state_next.cnt_cs = '0;
      state_next.cnt_per = state_reg.cnt_per + 7'h01;
    end else begin
      state_next.cnt_cs = state_reg.cnt_cs + 24'h000001;
    end
    // table writes clamped to the legal span
    if (pt_wr.we) begin
      state_next.px[pt_wr.idx] = (pt_wr.x > sds_pkg::PCT_FULL) ? sds_pkg::PCT_FULL : // see [RL9]
        (pt_wr.x < -sds_pkg::PCT_FULL) ? -sds_pkg::PCT_FULL : pt_wr.x;
      state_next.py[pt_wr.idx] = (pt_wr.y > sds_pkg::PCT_FULL) ? sds_pkg::PCT_FULL :
        (pt_wr.y < -sds_pkg::PCT_FULL) ? -sds_pkg::PCT_FULL : pt_wr.y;
    end
    // shared serial divider, one quotient bit per cycle
    t = {state_reg.rem, state_reg.num[55]};
    if (t >= {1'b0, state_reg.den}) begin
      t = t - {1'b0, state_reg.den};
      q1 = 1'b1;
    end
    nq = {state_reg.quo[54:0], q1};
    if (state_reg.st != sds_pkg::S_IDLE && state_reg.st != sds_pkg::S_SEG) begin
      state_next.num = {state_reg.num[54:0], 1'b0};
      state_next.rem = t[31:0];
      state_next.quo = nq;
      state_next.bitc = state_reg.bitc - 6'h01;
    end
    case (state_reg.st)
      sds_pkg::S_IDLE: begin
        if (state_next.cnt_per >= per) begin
          state_next.cnt_per = '0;
          // settings and frequency frozen here for the whole computation
          state_next.freq_s = freq_hz; // see [RL12]
          state_next.cfg_s = cfg;
          ppr = (cfg.ppr == 17'h00000) ? sds_pkg::PPR_MIN : (cfg.ppr > sds_pkg::PPR_MAX) ? sds_pkg::PPR_MAX : cfg.ppr;
          mult = (cfg.mult == 8'h00) ? sds_pkg::MULT_MIN : (cfg.mult > sds_pkg::MULT_MAX) ? sds_pkg::MULT_MAX : cfg.mult;
          case (cfg.unit)
            sds_pkg::UNIT_KHZ: k = sds_pkg::K_ONE; // see [RL2]
            sds_pkg::UNIT_RPS: k = sds_pkg::K_MILLI; // see [RL3]
            sds_pkg::UNIT_RPM: k = sds_pkg::K_RPM; // see [RL4]
            sds_pkg::UNIT_CUSTOM: k = 18'(sds_pkg::K_MILLI * mult); // see [RL5] see [RL7]
            default: k = sds_pkg::K_MILLI;
          endcase
          if (cfg.unit < sds_pkg::UNIT_RPS || cfg.unit > sds_pkg::UNIT_CUSTOM) begin
            ppr = sds_pkg::PPR_MIN; // see [RL6]
          end
          state_next.cfg_s.ppr = ppr;
          state_next.cfg_s.mult = mult;
          state_next.num = 56'(freq_hz) * 56'(k);
          state_next.den = 32'(ppr);
          state_next.rem = '0;
          state_next.quo = '0;
          state_next.bitc = sds_pkg::DIV_LAST;
          state_next.st = sds_pkg::S_DIVA;
        end
      end
      sds_pkg::S_DIVA: begin
        if (state_reg.bitc == 6'h00) begin
          state_next.disp_value = nq[31:0];
          if (state_reg.cfg_s.unit >= sds_pkg::UNIT_RPS && state_reg.cfg_s.unit <= sds_pkg::UNIT_CUSTOM) begin
            state_next.sw_value = nq[31:0]; // see [RL8]
          end else begin
            state_next.sw_value = 32'(56'(state_reg.freq_s) * 56'(sds_pkg::K_MILLI)); // see [RL2]
          end
          if (state_reg.cfg_s.lin_mode == sds_pkg::LIN_OFF || state_reg.cfg_s.full_scale == 32'h00000000) begin
            state_next.disp_valid = 1'b1;
            state_next.st = sds_pkg::S_IDLE;
          end else begin
            state_next.num = 56'(nq[31:0]) * 56'(sds_pkg::PCT_FULL);
            state_next.den = state_reg.cfg_s.full_scale;
            state_next.rem = '0;
            state_next.quo = '0;
            state_next.bitc = sds_pkg::DIV_LAST;
            state_next.st = sds_pkg::S_DIVB;
          end
        end
      end
      sds_pkg::S_DIVB: begin
        if (state_reg.bitc == 6'h00) begin
          // input never negative, so the percentage needs no sign fold before the table search
          state_next.pct = (nq > 56'(sds_pkg::PCT_FULL)) ? sds_pkg::PCT_FULL : 20'(nq);
          state_next.seg = '0;
          state_next.st = sds_pkg::S_SEG;
        end
      end
      sds_pkg::S_SEG: begin
        if (state_reg.seg == 4'hE || state_reg.pct <= $signed(state_reg.px[state_reg.seg + 4'h1])) begin
          dx = 21'($signed(state_reg.px[state_reg.seg + 4'h1])) - 21'($signed(state_reg.px[state_reg.seg]));
          dy = 21'($signed(state_reg.py[state_reg.seg + 4'h1])) - 21'($signed(state_reg.py[state_reg.seg]));
          dp = 21'(state_reg.pct) - 21'($signed(state_reg.px[state_reg.seg]));
          if (dp < 0) begin
            dp = '0;
          end
          if (dp > dx) begin
            dp = dx;
          end
          // a flat or falling pair of originals degrades to the lower substitute
          if (dx <= 0) begin
            dp = '0;
            dx = 21'sh1;
          end
          prod = 42'(dp) * 42'(dy); // see [RL10]
          state_next.neg = prod < 0;
          state_next.num = 56'((prod < 0) ? -prod : prod);
          state_next.den = 32'(dx);
          state_next.y0 = $signed(state_reg.py[state_reg.seg]);
          state_next.rem = '0;
          state_next.quo = '0;
          state_next.bitc = sds_pkg::DIV_LAST;
          state_next.st = sds_pkg::S_DIVC;
        end else begin
          state_next.seg = state_reg.seg + 4'h1;
        end
      end
      sds_pkg::S_DIVC: begin
        if (state_reg.bitc == 6'h00) begin
          lin = state_reg.neg ? 21'(state_reg.y0) - 21'(nq) : 21'(state_reg.y0) + 21'(nq); // see [RL10]
          state_next.pct = 20'(lin);
          state_next.num = (lin <= 0) ? '0 : 56'(lin) * 56'(state_reg.cfg_s.full_scale);
          state_next.den = 32'(sds_pkg::PCT_FULL);
          state_next.rem = '0;
          state_next.quo = '0;
          state_next.bitc = sds_pkg::DIV_LAST;
          state_next.st = sds_pkg::S_DIVD;
        end
      end
      sds_pkg::S_DIVD: begin
        if (state_reg.bitc == 6'h00) begin
          state_next.disp_value = nq[31:0];
          state_next.disp_valid = 1'b1;
          state_next.st = sds_pkg::S_IDLE;
        end
      end
      default: state_next.st = sds_pkg::S_IDLE;
    endcase
    // registered so the output leaves a flop, not a state decode
    state_next.busy = state_next.st != sds_pkg::S_IDLE;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.st <= sds_pkg::S_IDLE;
      state_reg.px <= {sds_pkg::N_POINTS{sds_pkg::PCT_FULL}};
      state_reg.py <= {sds_pkg::N_POINTS{sds_pkg::PCT_FULL}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign disp_value = state_reg.disp_value;
  assign sw_value = state_reg.sw_value;
  assign disp_valid = state_reg.disp_valid;
  assign busy = state_reg.busy;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic lin_off;
  assign lin_off = state_reg.cfg_s.lin_mode == sds_pkg::LIN_OFF || state_reg.cfg_s.full_scale == 32'h00000000;

  tick_bound_a: assert property (state_reg.cnt_cs < 24'(CYC_PER_CS)) else $error("period timer overrun"); // see [RL1]
  hz_value_a: assert property (disp_valid && lin_off && state_reg.cfg_s.unit == sds_pkg::UNIT_HZ // see [RL2]
    |-> disp_value == 32'(64'(state_reg.freq_s) * 64'(sds_pkg::K_MILLI))) else $error("hz display wrong");
  khz_sw_a: assert property (disp_valid && state_reg.cfg_s.unit == sds_pkg::UNIT_KHZ // see [RL2]
    |-> sw_value == 32'(64'(state_reg.freq_s) * 64'(sds_pkg::K_MILLI))
    && (!lin_off || disp_value == state_reg.freq_s)) else $error("khz scaling wrong");
  rps_value_a: assert property (disp_valid && lin_off && state_reg.cfg_s.unit == sds_pkg::UNIT_RPS // see [RL3]
    |-> disp_value == 32'(64'(state_reg.freq_s) * 64'(sds_pkg::K_MILLI) / 64'(state_reg.cfg_s.ppr)))
    else $error("rps wrong");
  rpm_value_a: assert property (disp_valid && lin_off && state_reg.cfg_s.unit == sds_pkg::UNIT_RPM // see [RL4]
    |-> disp_value == 32'(64'(state_reg.freq_s) * 64'(sds_pkg::K_RPM) / 64'(state_reg.cfg_s.ppr)))
    else $error("rpm wrong");
  custom_value_a: assert property (disp_valid && lin_off && state_reg.cfg_s.unit == sds_pkg::UNIT_CUSTOM // see [RL5]
    |-> disp_value == 32'(64'(state_reg.freq_s) * 64'(sds_pkg::K_MILLI) * 64'(state_reg.cfg_s.mult)
    / 64'(state_reg.cfg_s.ppr))) else $error("custom unit wrong");
  sw_units_a: assert property (disp_valid && state_reg.cfg_s.unit >= sds_pkg::UNIT_RPS // see [RL8]
    && state_reg.cfg_s.unit <= sds_pkg::UNIT_CUSTOM |-> !lin_off || sw_value == disp_value)
    else $error("threshold units wrong");
  table_range_a: assert property ( // see [RL9]
    pt_wr.we |=> $signed(state_reg.px[$past(pt_wr.idx)]) <= sds_pkg::PCT_FULL
    && $signed(state_reg.px[$past(pt_wr.idx)]) >= -sds_pkg::PCT_FULL
    && $signed(state_reg.py[$past(pt_wr.idx)]) <= sds_pkg::PCT_FULL
    && $signed(state_reg.py[$past(pt_wr.idx)]) >= -sds_pkg::PCT_FULL) else $error("point out of range");
  interp_span_a: assert property ( // see [RL10]
    state_reg.st == sds_pkg::S_DIVD && $past(state_reg.st) == sds_pkg::S_DIVC
    |-> (state_reg.pct >= state_reg.y0 && state_reg.pct <= $signed(state_reg.py[state_reg.seg + 4'h1]))
    || (state_reg.pct <= state_reg.y0 && state_reg.pct >= $signed(state_reg.py[state_reg.seg + 4'h1])))
    else $error("interpolation outside segment");
  snap_hold_a: assert property ( // see [RL12]
    busy && $past(busy) |-> $stable(state_reg.cfg_s) && $stable(state_reg.freq_s))
    else $error("settings changed mid computation");
  valid_done_a: assert property (disp_valid |-> !busy ##1 !disp_valid) else $error("valid not one cycle"); // see [RL1]

  rpm_lin_c: cover property (disp_valid && !lin_off && state_reg.cfg_s.unit == sds_pkg::UNIT_RPM);
  khz_c: cover property (disp_valid && state_reg.cfg_s.unit == sds_pkg::UNIT_KHZ);
  last_seg_c: cover property (state_reg.st == sds_pkg::S_SEG ##1 state_reg.st == sds_pkg::S_DIVC && state_reg.seg == 4'hE);
endmodule : sds_core

// File: include/sds_pkg.sv
// constants and carrier types for the speed display scaling block
package sds_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CS_TIME_NS = 10_000_000;
  localparam int unsigned CYC_PER_CS = CS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [6:0] UPD_MIN_CS = 7'h05;
  localparam logic [6:0] UPD_MAX_CS = 7'h64;
  localparam logic [6:0] UPD_DEF_CS = 7'h0A;
  // ************************************************************
  // units and scale factors (values carried in thousandths)
  // ************************************************************
  localparam logic [2:0] UNIT_HZ = 3'h0;
  localparam logic [2:0] UNIT_KHZ = 3'h1;
  localparam logic [2:0] UNIT_RPS = 3'h2;
  localparam logic [2:0] UNIT_RPM = 3'h3;
  localparam logic [2:0] UNIT_CUSTOM = 3'h4;
  localparam logic [17:0] K_MILLI = 18'h003E8;
  localparam logic [17:0] K_ONE = 18'h00001;
  localparam logic [17:0] K_RPM = 18'h0EA60;
  localparam logic [16:0] PPR_MIN = 17'h00001;
  localparam logic [16:0] PPR_MAX = 17'h1869F;
  localparam logic [7:0] MULT_MIN = 8'h01;
  localparam logic [7:0] MULT_MAX = 8'hC8;
  // ************************************************************
  // linearization
  // ************************************************************
  localparam int unsigned N_POINTS = 16;
  localparam logic [1:0] LIN_OFF = 2'h0;
  localparam logic signed [19:0] PCT_FULL = 20'sh186A0;
  localparam int unsigned DIV_W = 56;
  localparam logic [5:0] DIV_LAST = 6'h37;
  typedef struct packed {
    logic [6:0] upd_cs;
    logic [2:0] unit;
    logic [16:0] ppr;
    logic [7:0] mult;
    logic [1:0] lin_mode;
    logic [31:0] full_scale;
  } sds_cfg_s;
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic signed [19:0] x;
    logic signed [19:0] y;
  } sds_pt_wr_s;
  typedef enum {S_IDLE, S_DIVA, S_DIVB, S_SEG, S_DIVC, S_DIVD} sds_st_e;
endpackage : sds_pkg

// File: testbench/sds_core_tb_top.sv
// self-checking bench for the speed display scaling core
`timescale 1ns/1ps
module sds_core_tb_top;
  // ************************************************************
  // clock, reset and design hookup
  // ************************************************************
  logic clk_sys;
  logic resetn;
  logic [31:0] freq_hz;
  sds_pkg::sds_cfg_s cfg;
  sds_pkg::sds_pt_wr_s pt_wr;
  logic [31:0] disp_value;
  logic [31:0] sw_value;
  logic disp_valid;
  logic busy;
  int fails;
  int checks;
  int cyc;

  sds_core #(.CYC_PER_CS(10)) dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .freq_hz(freq_hz),
    .cfg(cfg),
    .pt_wr(pt_wr),
    .disp_value(disp_value),
    .sw_value(sw_value),
    .disp_valid(disp_valid),
    .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // sample at the falling edge so registered outputs have settled
  task automatic wait_valid;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (disp_valid !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      check(32'h0, 32'h1);
    end
  endtask : wait_valid

  // first result after a change may still use the old snapshot, so judge the second
  task automatic run(input logic [6:0] upd, input logic [2:0] unit, input logic [16:0] ppr,
                     input logic [7:0] mult, input logic [1:0] lin, input logic [31:0] fs,
                     input logic [31:0] freq, input logic [31:0] ed, input logic [31:0] es);
    @(posedge clk_sys);
    cfg <= '{upd_cs: upd, unit: unit, ppr: ppr, mult: mult, lin_mode: lin, full_scale: fs};
    freq_hz <= freq;
    wait_valid();
    wait_valid();
    check(disp_value, ed);
    check(sw_value, es);
  endtask : run

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_units;
    run(7'h0A, 3'h0, 17'h00007, 8'h01, 2'h0, 32'h0, 32'h4D2, 32'h12D450, 32'h12D450);
    run(7'h0A, 3'h1, 17'h00001, 8'h01, 2'h0, 32'h0, 32'h4D2, 32'h4D2, 32'h12D450);
    run(7'h0A, 3'h2, 17'h00004, 8'hC8, 2'h0, 32'h0, 32'h3E8, 32'h3D090, 32'h3D090);
    run(7'h0A, 3'h3, 17'h00020, 8'h01, 2'h0, 32'h0, 32'h64, 32'h2DC6C, 32'h2DC6C);
    run(7'h0A, 3'h4, 17'h00003, 8'hC8, 2'h0, 32'h0, 32'h64, 32'h65B9AA, 32'h65B9AA);
    run(7'h0A, 3'h5, 17'h00003, 8'h01, 2'h0, 32'h0, 32'h4D, 32'h12CC8, 32'h12CC8);
  endtask : t_units

  task automatic t_clamps;
    run(7'h0A, 3'h2, 17'h1FFFF, 8'h01, 2'h0, 32'h0, 32'h1869F, 32'h3E8, 32'h3E8);
    run(7'h0A, 3'h2, 17'h00000, 8'h01, 2'h0, 32'h0, 32'h5, 32'h1388, 32'h1388);
    run(7'h0A, 3'h4, 17'h00001, 8'hFF, 2'h0, 32'h0, 32'hA, 32'h1E8480, 32'h1E8480);
    run(7'h0A, 3'h4, 17'h00001, 8'h00, 2'h0, 32'h0, 32'hA, 32'h2710, 32'h2710);
  endtask : t_clamps

  // busy is high for the 56 divider cycles of an unlinearized result
  task automatic gap(input logic [6:0] upd, input logic [31:0] exp);
    int n;
    int nb;
    run(upd, 3'h0, 17'h00001, 8'h01, 2'h0, 32'h0, 32'h1, 32'h3E8, 32'h3E8);
    n = 0;
    nb = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (busy === 1'b1) begin
        nb++;
      end
    end while (disp_valid !== 1'b1 && n < 2000);
    check(n, exp);
    check(nb, 32'h38);
  endtask : gap

  task automatic t_period;
    gap(7'h14, 32'hC8);
    gap(7'h00, 32'h64);
    gap(7'h7F, 32'h3E8);
  endtask : t_period

  // originals rise strictly from point one to sixteen as the configuring side must
  task automatic t_lin;
    // out-of-range pair first to reach the clamp; the loop overwrites it
    @(posedge clk_sys);
    pt_wr <= '{we: 1'b1, idx: 4'hF, x: 20'sh7FFFF, y: 20'sh80000};
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      pt_wr.we <= 1'b1;
      pt_wr.idx <= i[3:0];
      pt_wr.x <= (i == 15) ? 20'sh186A0 : 20'(i * 6000);
      pt_wr.y <= (i == 15) ? 20'sh0C350 : 20'(i * 3000);
    end
    @(posedge clk_sys);
    pt_wr.we <= 1'b0;
    run(7'h32, 3'h0, 17'h00001, 8'h01, 2'h1, 32'hF4240, 32'h96, 32'h124F8, 32'h249F0);
    run(7'h32, 3'h0, 17'h00001, 8'h01, 2'h2, 32'hF4240, 32'h3E8, 32'h7A120, 32'hF4240);
    run(7'h32, 3'h0, 17'h00001, 8'h01, 2'h1, 32'hF4240, 32'hBB8, 32'h7A120, 32'h2DC6C0);
    run(7'h32, 3'h0, 17'h00001, 8'h01, 2'h0, 32'hF4240, 32'h96, 32'h249F0, 32'h249F0);
  endtask : t_lin

  // ************************************************************
  // main sequence and hang guard
  // ************************************************************
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    resetn = 1'b0;
    freq_hz = 32'h0;
    cfg = '{upd_cs: 7'h0A, unit: 3'h0, ppr: 17'h00001, mult: 8'h01, lin_mode: 2'h0, full_scale: 32'h0};
    pt_wr = '{we: 1'b0, idx: 4'h0, x: 20'sh0, y: 20'sh0};
    fails = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check(disp_value, 32'h0);
    check(32'(busy), 32'h0);
    t_units();
    t_clamps();
    t_period();
    t_lin();
    summarize();
  end
endmodule : sds_core_tb_top
